// ---- hw/bdo_pkg.sv ----
`default_nettype none
package bdo_pkg;
    // array organisation
    localparam int BANK_W      = 5;
    localparam int BLOCK_W     = 9;
    localparam int NUM_BLOCKS  = 259;
    localparam logic [BANK_W-1:0] PARAM_BANK = 5'h10;
    localparam logic PROT_RESET = 1'b1;

    // command codes on the command port
    typedef enum logic [3:0] {
        BDO_CMD_READ_ARRAY  = 4'h0,
        BDO_CMD_READ_STATUS = 4'h1,
        BDO_CMD_READ_QUERY  = 4'h2,
        BDO_CMD_READ_SIG    = 4'h3,
        BDO_CMD_PROGRAM     = 4'h4,
        BDO_CMD_ERASE       = 4'h5,
        BDO_CMD_SUSPEND     = 4'h6,
        BDO_CMD_RESUME      = 4'h7,
        BDO_CMD_PROTECT     = 4'h8,
        BDO_CMD_UNPROTECT   = 4'h9,
        BDO_CMD_OTP_PROGRAM = 4'ha,
        BDO_CMD_DONE        = 4'hb
    } bdo_cmd_type;

    // answer codes
    typedef enum logic [1:0] {
        BDO_ANS_OK        = 2'h0,
        BDO_ANS_SEQ_ERR   = 2'h1,
        BDO_ANS_PROT_ERR  = 2'h2,
        BDO_ANS_LOCK_ERR  = 2'h3
    } bdo_ans_type;

    // state of the one bank that may hold a program or erase
    typedef enum logic [2:0] {
        BDO_IDLE, BDO_PROG, BDO_ERASE, BDO_PROG_SUSP, BDO_ERASE_SUSP,
        BDO_OTP
    } bdo_op_type;
endpackage : bdo_pkg
`default_nettype wire

// ---- hw/bdo_prot_mem.sv ----
`default_nettype none
module bdo_prot_mem
    import bdo_pkg::*;
#(
    parameter int N = NUM_BLOCKS
)(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // write side
    input  wire logic               wr_en,
    input  wire logic [BLOCK_W-1:0] wr_blk,
    input  wire logic               wr_val,
    // read side: registered readout, gated by its enable
    input  wire logic               rd_en,
    input  wire logic [BLOCK_W-1:0] rd_blk,
    output var  logic               rd_val,
    // same-cycle look at the stored bit, for the admission check
    output var  logic               chk_val
);
    typedef struct packed {
        logic [N-1:0] bits;
        logic         rd;
    } bdo_mem_st_type;

    bdo_mem_st_type s_q;
    bdo_mem_st_type s_d;

    // a read in the same cycle as a write registers the old stored bit; the new value shows from the next cycle
    always_comb
    begin
        s_d = s_q;
        if (wr_en && (int'(wr_blk) < N))
            s_d.bits[wr_blk] = wr_val;
        s_d.rd = rd_en && chk_val;
    end

    // every block comes back protected on reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '{bits: {N{PROT_RESET}}, rd: 1'b0};
        else
            s_q <= s_d;
    end

    assign rd_val = s_q.rd;

    // a registered read would judge the block of the previous command;
    // blocks past the array count read as protected
    assign chk_val = (int'(rd_blk) < N) ? s_q.bits[rd_blk] : PROT_RESET;
endmodule : bdo_prot_mem
`default_nettype wire

// ---- hw/bdo_sync.sv ----
`default_nettype none
module bdo_sync
    import bdo_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // level in and out
    input  wire logic din,
    output var  logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } bdo_sync_st_type;

    bdo_sync_st_type s_q;
    bdo_sync_st_type s_d;

    // first stage feeds only the second
    always_comb
    begin
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign dout = s_q.s2;
endmodule : bdo_sync
`default_nettype wire

// ---- hw/bdo_bank_ctrl.sv ----
`default_nettype none
module bdo_bank_ctrl
    import bdo_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // command port, one command per valid cycle
    input  wire logic               cmd_valid,
    input  wire logic [3:0]         cmd_code,
    input  wire logic [BANK_W-1:0]  cmd_bank,
    input  wire logic [BLOCK_W-1:0] cmd_block,
    input  wire logic               cmd_param_blk,
    input  wire logic               cmd_word_hit,
    input  wire logic               cmd_setup_only,
    // supply monitor pin, asynchronous
    input  wire logic               program_lockout_threshold,
    // answer
    output var  logic               ans_valid,
    output var  logic [1:0]         ans_code,
    output var  logic               read_grant,
    output var  logic               read_data_valid,
    output var  logic               protection_state_bit,
    output var  logic               status_error,
    // engine side
    output var  logic               op_start,
    output var  logic               op_is_erase,
    output var  logic [BANK_W-1:0]  op_bank,
    output var  logic [BLOCK_W-1:0] op_block,
    output var  logic               op_suspend,
    output var  logic               op_resume,
    output var  logic               op_busy
);
    typedef struct packed {
        bdo_op_type         st;
        logic [BANK_W-1:0]  bank;
        logic [BLOCK_W-1:0] blk;
        logic               par;
        // program nested inside an erase suspend
        logic               nest;
        logic [BANK_W-1:0]  nbank;
        logic               ans_v;
        logic [1:0]         ans;
        logic               rgrant;
        logic               rvalid;
        logic               serr;
        logic               start;
        logic               is_er;
        logic               susp;
        logic               res;
        // registered copies of the engine-side levels
        logic               busy;
        logic [BANK_W-1:0]  obank;
    } bdo_st_type;

    bdo_st_type s_q;
    bdo_st_type s_d;
    logic       lockout;
    logic       prot_bit;
    logic       prot_now;
    logic       prot_re;
    logic       prot_we;
    logic       prot_wv;

    bdo_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (program_lockout_threshold),
        .dout   (lockout)
    );

    bdo_prot_mem u_prot (
        .clk    (clk),
        .resetn (resetn),
        .wr_en  (prot_we),
        .wr_blk (cmd_block),
        .wr_val (prot_wv),
        .rd_en   (prot_re),
        .rd_blk  (cmd_block),
        .rd_val  (prot_bit),
        .chk_val (prot_now)
    );

    // true when a command is a read of some space
    function automatic logic is_read(input logic [3:0] c);
        return c == BDO_CMD_READ_ARRAY || c == BDO_CMD_READ_STATUS ||
               c == BDO_CMD_READ_QUERY || c == BDO_CMD_READ_SIG;
    endfunction : is_read

    // dual-operation limits for a read while something is busy
    function automatic logic read_ok(input bdo_st_type s,
                                     input logic [3:0] c,
                                     input logic [BANK_W-1:0] b,
                                     input logic pb);
        logic spc;
        logic inpar;
        logic active;
        spc    = c == BDO_CMD_READ_QUERY || c == BDO_CMD_READ_SIG;
        inpar  = b == PARAM_BANK;
        active = s.st == BDO_PROG || s.st == BDO_ERASE;
        read_ok = 1'b1;
        if (s.st == BDO_OTP)
            read_ok = 1'b0;
        else if (active && s.par)
            read_ok = !spc && !inpar;
        else if (active && s.bank == PARAM_BANK)
            read_ok = !inpar;
        // same-bank array reads are taken; the caller flags their data unless a program is nested in an erase suspend
        else if (active && !pb && !inpar && c == BDO_CMD_READ_ARRAY)
            read_ok = 1'b1;
    endfunction : read_ok

    logic same;
    logic susp_st;
    logic busy_st;

    always_comb
    begin
        s_d         = s_q;
        s_d.ans_v   = 1'b0;
        s_d.ans     = BDO_ANS_OK;
        s_d.rgrant  = 1'b0;
        s_d.rvalid  = 1'b0;
        prot_re     = 1'b0;
        s_d.start   = 1'b0;
        s_d.susp    = 1'b0;
        s_d.res     = 1'b0;
        prot_we     = 1'b0;
        prot_wv     = PROT_RESET;
        same        = cmd_bank == s_q.bank;
        susp_st     = s_q.st == BDO_PROG_SUSP || s_q.st == BDO_ERASE_SUSP;
        busy_st     = s_q.st == BDO_PROG || s_q.st == BDO_ERASE ||
                      s_q.st == BDO_OTP;
        // engine reports completion of the running operation
        if (cmd_valid && cmd_code == BDO_CMD_DONE)
        begin
            if (s_q.nest)
            begin
                s_d.nest = 1'b0;
                s_d.st   = BDO_ERASE_SUSP;
            end
            else if (busy_st)
                s_d.st = BDO_IDLE;
            s_d.serr = 1'b0;
        end
        else if (cmd_valid)
        begin
            s_d.ans_v = 1'b1;
            unique case (cmd_code)
            BDO_CMD_READ_ARRAY, BDO_CMD_READ_STATUS,
            BDO_CMD_READ_QUERY, BDO_CMD_READ_SIG:
            begin
                // reads elsewhere stay open except during BDO_OTP or, for query and signature reads, while a parameter block is busy; setup too
                if (s_q.st == BDO_IDLE || cmd_setup_only ||
                    read_ok(s_q, cmd_code, cmd_bank, cmd_param_blk))
                begin
                    s_d.rgrant = 1'b1;
                    s_d.rvalid = 1'b1;
                    if (cmd_code == BDO_CMD_READ_ARRAY && same && !s_q.nest)
                    begin
                        if (busy_st)
                            s_d.rvalid = 1'b0;
                        else if (susp_st && (cmd_block == s_q.blk) &&
                                 (s_q.st == BDO_ERASE_SUSP || cmd_word_hit))
                        begin
                            s_d.rgrant = 1'b0;
                            s_d.rvalid = 1'b0;
                            s_d.ans    = BDO_ANS_SEQ_ERR;
                        end
                    end
                    prot_re = cmd_code == BDO_CMD_READ_SIG;
                end
                else
                    s_d.ans = BDO_ANS_SEQ_ERR;
            end
            BDO_CMD_PROGRAM, BDO_CMD_ERASE, BDO_CMD_OTP_PROGRAM:
            begin
                if (cmd_setup_only)
                    s_d.ans = BDO_ANS_OK;
                else if (!(s_q.st == BDO_IDLE ||
                      (s_q.st == BDO_ERASE_SUSP && !s_q.nest &&
                       cmd_code == BDO_CMD_PROGRAM &&
                       cmd_block != s_q.blk)))
                    s_d.ans = BDO_ANS_SEQ_ERR;
                else if (lockout)
                begin
                    s_d.ans  = BDO_ANS_LOCK_ERR;
                    s_d.serr = 1'b1;
                end
                else if (prot_now && cmd_code != BDO_CMD_OTP_PROGRAM)
                begin
                    s_d.ans  = BDO_ANS_PROT_ERR;
                    s_d.serr = 1'b1;
                end
                else
                begin
                    s_d.start = 1'b1;
                    s_d.is_er = cmd_code == BDO_CMD_ERASE;
                    if (s_q.st == BDO_ERASE_SUSP)
                    begin
                        s_d.nest  = 1'b1;
                        s_d.nbank = cmd_bank;
                        s_d.st    = BDO_PROG;
                    end
                    else
                    begin
                        s_d.bank = cmd_bank;
                        s_d.blk  = cmd_block;
                        s_d.par  = cmd_param_blk;
                        s_d.st   = cmd_code == BDO_CMD_ERASE ? BDO_ERASE :
                                   cmd_code == BDO_CMD_PROGRAM ? BDO_PROG :
                                   BDO_OTP;
                    end
                end
            end
            BDO_CMD_SUSPEND:
            begin
                if ((s_q.st == BDO_PROG || s_q.st == BDO_ERASE) && !s_q.nest)
                begin
                    s_d.susp = 1'b1;
                    s_d.st   = s_q.st == BDO_ERASE ? BDO_ERASE_SUSP :
                               BDO_PROG_SUSP;
                end
                else
                    s_d.ans = BDO_ANS_SEQ_ERR;
            end
            BDO_CMD_RESUME:
            begin
                // erase resumes even if its block became protected
                if (susp_st && !s_q.nest)
                begin
                    s_d.res = 1'b1;
                    s_d.st  = s_q.st == BDO_ERASE_SUSP ? BDO_ERASE : BDO_PROG;
                end
                else
                    s_d.ans = BDO_ANS_SEQ_ERR;
            end
            BDO_CMD_PROTECT, BDO_CMD_UNPROTECT:
            begin
                if (s_q.st == BDO_IDLE ||
                    (s_q.st == BDO_ERASE_SUSP && !s_q.nest))
                begin
                    prot_we = 1'b1;
                    prot_wv = cmd_code == BDO_CMD_PROTECT;
                end
                else
                    s_d.ans = BDO_ANS_SEQ_ERR;
            end
            default:
                s_d.ans = BDO_ANS_SEQ_ERR;
            endcase
        end
        // levels for the engine leave straight from flops, no output glitch
        s_d.busy  = s_d.st == BDO_PROG || s_d.st == BDO_ERASE ||
                    s_d.st == BDO_OTP;
        s_d.obank = s_d.nest ? s_d.nbank : s_d.bank;
    end

    // one clocked process for the whole control state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q       <= '0;
            s_q.st    <= BDO_IDLE;
        end
        else
            s_q <= s_d;
    end

    // protect bit arrives from the memory's register, one cycle after
    assign ans_valid            = s_q.ans_v;
    assign ans_code             = s_q.ans;
    assign read_grant           = s_q.rgrant;
    assign read_data_valid      = s_q.rvalid;
    assign protection_state_bit = prot_bit;
    assign status_error         = s_q.serr;
    assign op_start             = s_q.start;
    assign op_is_erase          = s_q.is_er;
    assign op_bank              = s_q.obank;
    assign op_block             = s_q.blk;
    assign op_suspend           = s_q.susp;
    assign op_resume            = s_q.res;
    assign op_busy              = s_q.busy;
endmodule : bdo_bank_ctrl
`default_nettype wire

// ---- testbench/bdo_assertions.sv ----
`default_nettype none
module bdo_checker
    import bdo_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // command side
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_code,
    input wire logic        cmd_setup_only,
    input wire logic        program_lockout_threshold,
    // answer and engine side
    input wire logic        ans_valid,
    input wire logic [1:0]  ans_code,
    input wire logic        read_grant,
    input wire logic        protection_state_bit,
    input wire logic        status_error,
    input wire logic        op_start,
    input wire logic        op_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // a program or erase that really asks for work, not a setup cycle
    sequence s_pe_cmd;
        cmd_valid && !cmd_setup_only && (cmd_code inside {4'h4, 4'h5});
    endsequence
    // lockout held long enough to get through the two-flop sync
    sequence s_locked;
        program_lockout_threshold [*4];
    endsequence

    a_lock_refuse: assert property (s_locked ##0 !op_busy ##0 s_pe_cmd |=>
        ans_valid && ans_code == 2'h3 && !op_start)
        else $error("program or erase started under supply lockout");
    a_err_sticky: assert property (ans_valid && ans_code[1] |->
        ##[0:1] status_error)
        else $error("protect or lockout refusal left no status error");
    a_sig_source: assert property (protection_state_bit |->
        $past(cmd_valid) && $past(cmd_code) == 4'h3)
        else $error("protect bit shown without a signature read");
    a_ans_follows: assert property (cmd_valid && cmd_code != 4'hb |=>
        ans_valid)
        else $error("command got no answer one cycle later");
    a_quiet_idle: assert property (!cmd_valid |=> !ans_valid && !op_start)
        else $error("answer or start without a command");
    a_start_cause: assert property (op_start |->
        $past(cmd_valid) && ans_code == 2'h0 && op_busy)
        else $error("start without an accepted command");
    a_start_single: assert property (op_start |=> !op_start)
        else $error("two starts in a row");
    a_busy_end: assert property ($fell(op_busy) |->
        $past(cmd_valid) && ($past(cmd_code) inside {4'hb, 4'h6}))
        else $error("busy dropped without done or suspend");
    a_grant_ok: assert property (read_grant |-> ans_valid && !ans_code)
        else $error("read granted with a refusal code");
    a_refuse_quiet: assert property (ans_valid && ans_code == 2'h1 |->
        !op_start)
        else $error("refused command still started work");
endmodule : bdo_checker

bind bdo_bank_ctrl bdo_checker i_chk (.clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_setup_only(cmd_setup_only),
    .program_lockout_threshold(program_lockout_threshold),
    .ans_valid(ans_valid), .ans_code(ans_code), .read_grant(read_grant),
    .protection_state_bit(protection_state_bit),
    .status_error(status_error), .op_start(op_start), .op_busy(op_busy));
`default_nettype wire

// ---- testbench/bdo_host_model.sv ----
`default_nettype none
module bdo_host_model
    import bdo_pkg::*;
(
    // clock
    input  wire logic               clk,
    // command lines toward the block
    output var  logic               cmd_valid,
    output var  logic [3:0]         cmd_code,
    output var  logic [BANK_W-1:0]  cmd_bank,
    output var  logic [BLOCK_W-1:0] cmd_block,
    output var  logic               cmd_param_blk,
    output var  logic               cmd_word_hit,
    output var  logic               cmd_setup_only,
    output var  logic               program_lockout_threshold
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet bus at time zero, supply healthy
    initial
    begin
        {cmd_valid, cmd_code, cmd_bank, cmd_block} = '0;
        {cmd_param_blk, cmd_word_hit, cmd_setup_only} = 3'h0;
        program_lockout_threshold = 1'b0;
    end

    // one command per call; the caller also reads a busy bank and tries to change
    // protection mid-erase with no suspend first, which is refused
    task automatic issue(input bdo_cmd_type c, input logic [4:0] b,
                         input logic [8:0] k, input logic s);
        @(negedge clk);
        cmd_valid      = 1'b1;
        cmd_code       = c;
        cmd_bank       = b;
        cmd_block      = k;
        cmd_setup_only = s;
        @(negedge clk);
        // released lines must not keep showing the last command
        cmd_valid      = 1'b0;
        cmd_code       = ~c;
        cmd_bank       = ~b;
        cmd_block      = ~k;
        cmd_setup_only = ~s;
    endtask : issue

    // address qualifiers that the plain issue task leaves alone
    task automatic set_flags(input logic p, input logic w);
        @(negedge clk);
        cmd_param_blk = p;
        cmd_word_hit  = w;
    endtask : set_flags

    // supply level changes land off the sampling edge
    task automatic set_lock(input logic v);
        @(negedge clk);
        program_lockout_threshold = v;
    endtask : set_lock
endmodule : bdo_host_model
`default_nettype wire

// ---- testbench/bank_dual_op_protection_tb.sv ----
`default_nettype none
module bank_dual_op_protection_tb;
    import bdo_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, resetn = 1'b0;
    logic cv, cpb, cwh, cso, lock;
    logic [3:0] cc;
    logic [4:0] cb, obk;
    logic [8:0] ck, obl;
    logic av, rg, rdv, psb, serr, ost, oer, osu, ors, obs;
    logic [1:0] ac;
    int mismatches = 0, n_checks = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    bdo_host_model i_host (.clk(clk), .cmd_valid(cv), .cmd_code(cc),
        .cmd_bank(cb), .cmd_block(ck), .cmd_param_blk(cpb),
        .cmd_word_hit(cwh), .cmd_setup_only(cso),
        .program_lockout_threshold(lock));

    bdo_bank_ctrl i_dut (.clk(clk), .resetn(resetn), .cmd_valid(cv),
        .cmd_code(cc), .cmd_bank(cb), .cmd_block(ck), .cmd_param_blk(cpb),
        .cmd_word_hit(cwh), .cmd_setup_only(cso),
        .program_lockout_threshold(lock), .ans_valid(av), .ans_code(ac),
        .read_grant(rg), .read_data_valid(rdv), .protection_state_bit(psb),
        .status_error(serr), .op_start(ost), .op_is_erase(oer),
        .op_bank(obk), .op_block(obl), .op_suspend(osu), .op_resume(ors),
        .op_busy(obs));

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // answer is registered, so it is settled at the falling edge after
    task automatic cmd(input bdo_cmd_type c, input logic [4:0] b,
                       input logic [8:0] k, input logic s = 1'b0);
        i_host.issue(c, b, k, s);
    endtask : cmd

    task automatic do_reset;
        @(negedge clk);
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
    endtask : do_reset

    task automatic t_reset_state;
        cmd(BDO_CMD_READ_SIG, 0, 5);
        chk(psb, 1);
        cmd(BDO_CMD_PROGRAM, 0, 5);
        chk(ac, BDO_ANS_PROT_ERR);
        chk(ost, 0);
        cmd(BDO_CMD_UNPROTECT, 0, 5);
        chk(serr, 1);
        cmd(BDO_CMD_UNPROTECT, 1, 20);
        cmd(BDO_CMD_READ_SIG, 0, 5);
        chk(psb, 0);
    endtask : t_reset_state

    task automatic t_program_busy;
        cmd(BDO_CMD_PROGRAM, 0, 5);
        chk({ost, obk, obl[2:0]}, {1'b1, 5'h0, 3'h5});
        cmd(BDO_CMD_READ_ARRAY, 2, 40);
        chk({rg, rdv}, 2'h3);
        cmd(BDO_CMD_ERASE, 1, 20);
        chk({ac, obs}, {BDO_ANS_SEQ_ERR, 1'b1});
        cmd(BDO_CMD_RESUME, 1, 20);
        chk(ac, BDO_ANS_SEQ_ERR);
        cmd(BDO_CMD_READ_STATUS, 0, 5);
        chk({av, ac}, 3'h4);
        cmd(BDO_CMD_READ_ARRAY, 0, 5);
        chk({rg, rdv}, 2'h2);
        cmd(BDO_CMD_DONE, 0, 5);
        chk({obs, serr}, 2'h0);
    endtask : t_program_busy

    task automatic t_erase_suspend;
        cmd(BDO_CMD_ERASE, 1, 20);
        chk({ost, oer}, 2'h3);
        cmd(BDO_CMD_PROTECT, 1, 20);
        chk(ac, BDO_ANS_SEQ_ERR);
        cmd(BDO_CMD_SUSPEND, 1, 20);
        chk(osu, 1);
        cmd(BDO_CMD_READ_STATUS, 1, 20);
        cmd(BDO_CMD_READ_ARRAY, 1, 20);
        chk(rg, 0);
        cmd(BDO_CMD_PROTECT, 1, 20);
        chk(ac, BDO_ANS_OK);
        cmd(BDO_CMD_READ_SIG, 1, 20);
        chk(psb, 1);
        cmd(BDO_CMD_PROGRAM, 0, 5);
        chk({ac, ost}, 3'h1);
        cmd(BDO_CMD_DONE, 0, 5);
        cmd(BDO_CMD_RESUME, 1, 20);
        chk(ors, 1);
        cmd(BDO_CMD_DONE, 1, 20);
        chk(obs, 0);
    endtask : t_erase_suspend

    task automatic t_setup_and_prog_suspend;
        cmd(BDO_CMD_PROGRAM, 0, 5, 1'b1);
        chk({ac, ost}, 3'h0);
        cmd(BDO_CMD_READ_ARRAY, 2, 40);
        chk(rg, 1);
        cmd(BDO_CMD_PROGRAM, 0, 5);
        cmd(BDO_CMD_SUSPEND, 0, 5);
        cmd(BDO_CMD_UNPROTECT, 2, 40);
        chk(ac, BDO_ANS_SEQ_ERR);
        cmd(BDO_CMD_RESUME, 0, 5);
        cmd(BDO_CMD_DONE, 0, 5);
    endtask : t_setup_and_prog_suspend

    // block 5 is still unprotected, so only the supply can refuse it
    task automatic t_lockout;
        i_host.set_lock(1'b1);
        repeat (4) @(negedge clk);
        cmd(BDO_CMD_PROGRAM, 0, 5);
        chk({ac, ost}, 3'h6);
        i_host.set_lock(1'b0);
        repeat (4) @(negedge clk);
    endtask : t_lockout

    // parameter block, otp and word-hit corners of the admission tables
    task automatic t_corner;
        i_host.set_flags(1'b1, 1'b0);
        cmd(BDO_CMD_UNPROTECT, 16, 3);
        cmd(BDO_CMD_PROGRAM, 16, 3);
        chk(ost, 1);
        i_host.set_flags(1'b0, 1'b0);
        cmd(BDO_CMD_READ_QUERY, 2, 40);
        chk(ac, BDO_ANS_SEQ_ERR);
        cmd(BDO_CMD_READ_ARRAY, 2, 40);
        chk(rg, 1);
        cmd(BDO_CMD_DONE, 16, 3);
        cmd(BDO_CMD_OTP_PROGRAM, 3, 7);
        chk(ost, 1);
        cmd(BDO_CMD_READ_ARRAY, 2, 40);
        chk(rg, 0);
        cmd(BDO_CMD_DONE, 3, 7);
        cmd(BDO_CMD_PROGRAM, 0, 5);
        cmd(BDO_CMD_SUSPEND, 0, 5);
        i_host.set_flags(1'b0, 1'b1);
        cmd(BDO_CMD_READ_ARRAY, 0, 5);
        chk(rg, 0);
        i_host.set_flags(1'b0, 1'b0);
        cmd(BDO_CMD_READ_ARRAY, 0, 5);
        chk(rg, 1);
        cmd(BDO_CMD_RESUME, 0, 5);
        cmd(BDO_CMD_DONE, 0, 5);
        chk(obs, 0);
    endtask : t_corner

    task automatic t_rereset;
        do_reset();
        cmd(BDO_CMD_READ_SIG, 0, 5);
        chk(psb, 1);
    endtask : t_rereset

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_reset_state();
        t_program_busy();
        t_erase_suspend();
        t_setup_and_prog_suspend();
        t_lockout();
        t_corner();
        t_rereset();
        print_verdict();
    end

    // bound on the whole run in case the sequence hangs
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : bank_dual_op_protection_tb
`default_nettype wire
